// ==== verilog/exec_ops.v ====
// Execution unit for bit clear, returns and left rotates of an 8-bit core.
// Assumes memory answers a read in the cycle after mem_rd_reg, and takes writes at once.
// Notes on behaviour
// - Bit clear forces the indexed bit of the operand to zero and keeps the rest.
// - Register field codes 0-5 and 7 pick B, C, D, E, H, L and A.
// - Bit clear lasts 8 states on a register, 15 through the pointer pair, 23 indexed.
// - Return pops the program counter and continues there in 10 states.
// - Conditional return pops in 11 states when taken, else goes on after 5 states.
// - Condition codes 0-7 are NZ, Z, NC, C, PO, PE, P, M.
// - Interrupt return pops in 14 states and pulses a marker for peripherals.
// - NMI return pops in 14 states then copies the saved enable into the active one.
// - Rotate through carry shifts left, old carry to bit 0, old bit 7 to carry.
// - Accumulator rotate through carry is a 9-bit rotate lasting 4 states.
// - Accumulator circular rotate copies old bit 7 to bit 0 and carry.
// - Accumulator circular rotate matches the register form except for flags.
// - Register circular rotate uses CB then 07 or 00-05 and lasts 8 states.
// - Register circular rotate sets carry, clears H and N, updates S, Z, parity.
// - A pop reads the low byte at the stack pointer, high at plus one, adds two.
`timescale 1ns/1ps
`default_nettype none
`include "exec_ops_regs.vh"
module exec_ops (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Instruction bytes from fetch: prefix (00 when none), opcode, index offset
  input wire instr_valid,
  input wire [7:0] instr_prefix,
  input wire [7:0] instr_opcode,
  input wire [7:0] instr_offset,
  input wire [15:0] next_pc,
  // Index register values
  input wire [15:0] first_index_register,
  input wire [15:0] second_index_register,
  // Interrupt enable requests from the rest of the core
  input wire interrupt_enable_op,
  // Memory bus
  input wire [7:0] mem_rdata,
  output reg [15:0] mem_addr_reg,
  output reg [7:0] mem_wdata_reg,
  output reg mem_rd_reg,
  output reg mem_wr_reg,
  // Status
  output reg busy_reg,
  output reg done_reg,
  output reg [15:0] pc_reg,
  output reg [15:0] stack_pointer_reg,
  output reg [7:0] acc_reg,
  output reg [7:0] flags_reg,
  output reg [47:0] gpr_reg,
  output reg active_int_enable_ff,
  output reg saved_int_enable_ff,
  output reg interrupt_return_op_seen_reg
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_RD = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_POP_LO = 3'h4;
  localparam ST_POP_HI = 3'h5;
  localparam ST_FINISH = 3'h6;
  localparam ST_POP_END = 3'h7;
  reg [2:0] state_reg;
  reg [4:0] tcount_reg;
  reg [2:0] op_reg;
  reg [2:0] bit_reg;
  reg [2:0] dst_reg;
  reg [1:0] ret_kind_reg;
  reg [7:0] rd_byte_reg;
  reg [2:0] alu_op;
  reg [7:0] alu_in;
  wire [7:0] alu_out;
  wire [7:0] alu_flags;
  wire is_cb;
  wire is_idx;
  wire [2:0] rfield;
  wire [15:0] hl_pair;
  reg cond_true;
  reg [7:0] reg_val;
  assign is_cb = (instr_prefix == `OP_PREFIX_CB) || ((instr_prefix == `OP_PREFIX_IX) ||
    (instr_prefix == `OP_PREFIX_IY));
  assign is_idx = (instr_prefix == `OP_PREFIX_IX) || (instr_prefix == `OP_PREFIX_IY);
  assign rfield = instr_opcode[2:0];
  assign hl_pair = gpr_reg[15:0];
  // GPR layout: B 47:40, C 39:32, D 31:24, E 23:16, H 15:8, L 7:0
  always @*
  begin
    reg_val = acc_reg;
    case (rfield)
      3'h0: reg_val = gpr_reg[47:40];
      3'h1: reg_val = gpr_reg[39:32];
      3'h2: reg_val = gpr_reg[31:24];
      3'h3: reg_val = gpr_reg[23:16];
      3'h4: reg_val = gpr_reg[15:8];
      3'h5: reg_val = gpr_reg[7:0];
      default: reg_val = acc_reg;
    endcase
  end
  always @*
  begin
    cond_true = 1'b0;
    case (instr_opcode[5:4])
      2'h0: cond_true = ~flags_reg[`FLAG_Z];
      2'h1: cond_true = ~flags_reg[`FLAG_C];
      2'h2: cond_true = ~flags_reg[`FLAG_PV];
      default: cond_true = ~flags_reg[`FLAG_S];
    endcase
    if (instr_opcode[3])
      cond_true = ~cond_true;
  end
  always @*
  begin
    alu_op = op_reg;
    alu_in = (state_reg == ST_WR) ? rd_byte_reg : reg_val;
    if (state_reg == ST_IDLE)
    begin
      if (is_cb)
        alu_op = (instr_opcode[7:6] == 2'h2) ? 3'h2 : ((instr_opcode[5:3] == 3'h0) ? 3'h0 : 3'h1);
      else
        alu_op = (instr_opcode == `OP_ACC_CIRCULAR_LEFT_OP) ? 3'h3 : 3'h4;
      if (!is_cb)
        alu_in = acc_reg;
    end
  end
  rot_bit_alu u_alu (
    .op_sel(alu_op),
    .bit_index((state_reg == ST_IDLE) ? instr_opcode[5:3] : bit_reg),
    .data_in(alu_in),
    .flags_in(flags_reg),
    .data_out(alu_out),
    .flags_out(alu_flags)
  );
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      tcount_reg <= 5'h00;
      op_reg <= 3'h0;
      bit_reg <= 3'h0;
      dst_reg <= 3'h0;
      ret_kind_reg <= 2'h0;
      rd_byte_reg <= 8'h00;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      pc_reg <= `PC_RESET;
      stack_pointer_reg <= `SP_RESET;
      acc_reg <= 8'h00;
      flags_reg <= `FLAGS_RESET;
      gpr_reg <= 48'h000000000000;
      active_int_enable_ff <= 1'b0;
      saved_int_enable_ff <= 1'b0;
      interrupt_return_op_seen_reg <= 1'b0;
    end
    else
    begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      done_reg <= 1'b0;
      interrupt_return_op_seen_reg <= 1'b0;
      if (interrupt_enable_op)
      begin
        // Software enables before returning from a maskable interrupt
        active_int_enable_ff <= 1'b1;
        saved_int_enable_ff <= 1'b1;
      end
      if (tcount_reg != 5'h00)
        tcount_reg <= tcount_reg - 5'h01;
      case (state_reg)
        ST_IDLE:
          if (instr_valid)
          begin
            busy_reg <= 1'b1;
            pc_reg <= next_pc;
            op_reg <= alu_op;
            bit_reg <= instr_opcode[5:3];
            dst_reg <= rfield;
            ret_kind_reg <= 2'h0;
            state_reg <= ST_WAIT;
            if (instr_prefix == `OP_PREFIX_ED || instr_opcode == `OP_RETURN ||
              (instr_prefix == 8'h00 && instr_opcode[7:6] == 2'h3 && rfield == 3'h0))
            begin
              mem_addr_reg <= stack_pointer_reg;
              mem_rd_reg <= 1'b1;
              state_reg <= ST_POP_LO;
              // Counter holds the whole state count, so done lands on its last cycle
              if (instr_prefix == `OP_PREFIX_ED)
              begin
                tcount_reg <= `T_RET_ED;
                ret_kind_reg <= (instr_opcode == `OP_NMI_RETURN_OP_2ND) ? 2'h2 : 2'h1;
              end
              else if (instr_opcode == `OP_RETURN)
                tcount_reg <= `T_RET;
              else if (cond_true)
                tcount_reg <= `T_RETCC_TAKEN;
              else
              begin
                mem_rd_reg <= 1'b0;
                tcount_reg <= `T_RETCC_SKIP;
                state_reg <= ST_FINISH;
              end
            end
            else if (is_cb && (is_idx || rfield == `REG_CODE_MEM))
            begin
              mem_addr_reg <= is_idx ? (((instr_prefix == `OP_PREFIX_IX) ? first_index_register :
                second_index_register) + {{8{instr_offset[7]}}, instr_offset}) : hl_pair;
              mem_rd_reg <= 1'b1;
              state_reg <= ST_RD;
              tcount_reg <= is_idx ? `T_IDX_OP : `T_MEM_OP;
            end
            else if (is_cb)
            begin
              tcount_reg <= `T_REG_OP;
              dst_reg <= rfield;
              state_reg <= ST_FINISH;
              if (alu_op != 3'h2)
                flags_reg <= alu_flags;
              case (rfield)
                3'h0: gpr_reg[47:40] <= alu_out;
                3'h1: gpr_reg[39:32] <= alu_out;
                3'h2: gpr_reg[31:24] <= alu_out;
                3'h3: gpr_reg[23:16] <= alu_out;
                3'h4: gpr_reg[15:8] <= alu_out;
                3'h5: gpr_reg[7:0] <= alu_out;
                default: acc_reg <= alu_out;
              endcase
            end
            else
            begin
              acc_reg <= alu_out;
              flags_reg <= alu_flags;
              tcount_reg <= `T_ACC_OP;
              state_reg <= ST_FINISH;
            end
          end
        ST_RD:
          state_reg <= ST_WAIT;
        ST_WAIT:
        begin
          rd_byte_reg <= mem_rdata;
          state_reg <= ST_WR;
        end
        ST_WR:
        begin
          mem_wdata_reg <= alu_out; // Same address as the read
          mem_wr_reg <= 1'b1;
          if (op_reg != 3'h2)
            flags_reg <= alu_flags;
          state_reg <= ST_FINISH;
        end
        ST_POP_LO:
        begin
          // Second read goes out while the first answer is still in flight
          mem_addr_reg <= stack_pointer_reg + 16'h0001;
          mem_rd_reg <= 1'b1;
          state_reg <= ST_POP_HI;
        end
        ST_POP_HI:
        begin
          pc_reg[7:0] <= mem_rdata;
          state_reg <= ST_POP_END;
        end
        ST_POP_END:
        begin
          pc_reg[15:8] <= mem_rdata;
          stack_pointer_reg <= stack_pointer_reg + 16'h0002;
          // An enable request in the same cycle wins over the copy
          if (ret_kind_reg == 2'h2 && !interrupt_enable_op)
            active_int_enable_ff <= saved_int_enable_ff;
          if (ret_kind_reg == 2'h1)
            interrupt_return_op_seen_reg <= 1'b1;
          state_reg <= ST_FINISH;
        end
        default:
          if (tcount_reg <= 5'h01)
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verilog/exec_ops_regs.vh ====
// Constants for the bit-clear, return and left-rotate execution block.
// Assumes inclusion by the execution block and its byte unit only.
`ifndef EXEC_OPS_REGS_VH
`define EXEC_OPS_REGS_VH
// Opcode bytes
`define OP_PREFIX_CB 8'hCB
`define OP_PREFIX_ED 8'hED
`define OP_PREFIX_IX 8'hDD
`define OP_PREFIX_IY 8'hFD
`define OP_RETURN 8'hC9
`define OP_INTERRUPT_RETURN_OP_2ND 8'h4D
`define OP_NMI_RETURN_OP_2ND 8'h45
`define OP_RLA 8'h17
`define OP_ACC_CIRCULAR_LEFT_OP 8'h07
// Register field code of the memory operand
`define REG_CODE_MEM 3'h6
// Flag bit positions
`define FLAG_C 0
`define FLAG_N 1
`define FLAG_PV 2
`define FLAG_H 4
`define FLAG_Z 6
`define FLAG_S 7
// Clock-state counts per operation
`define T_REG_OP 5'h08
`define T_MEM_OP 5'h0F
`define T_IDX_OP 5'h17
`define T_RET 5'h0A
`define T_RETCC_TAKEN 5'h0B
`define T_RETCC_SKIP 5'h05
`define T_RET_ED 5'h0E
`define T_ACC_OP 5'h04
// Reset values
`define SP_RESET 16'hFFFF
`define PC_RESET 16'h0000
`define FLAGS_RESET 8'h00
`endif

// ==== verilog/rot_bit_alu.v ====
// Byte unit: bit clear and left rotates with their flag results.
// Assumes purely combinational use by the execution block.
`timescale 1ns/1ps
`default_nettype none
`include "exec_ops_regs.vh"
module rot_bit_alu (
  // Operation select: 0 circular, 1 through carry, 2 bit clear, 3 acc circular, 4 acc through carry
  input wire [2:0] op_sel,
  input wire [2:0] bit_index,
  // Operands
  input wire [7:0] data_in,
  input wire [7:0] flags_in,
  // Results
  output reg [7:0] data_out,
  output reg [7:0] flags_out
);
  always @*
  begin
    data_out = data_in;
    flags_out = flags_in;
    case (op_sel)
      3'h0, 3'h1:
      begin
        data_out = {data_in[6:0], (op_sel == 3'h0) ? data_in[7] : flags_in[`FLAG_C]};
        flags_out[`FLAG_C] = data_in[7];
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
        flags_out[`FLAG_S] = data_out[7];
        flags_out[`FLAG_Z] = (data_out == 8'h00);
        flags_out[`FLAG_PV] = ~(^data_out);
      end
      3'h2:
        data_out[bit_index] = 1'b0;
      3'h3, 3'h4:
      begin
        // Same data as register forms, only carry, H and N touched
        data_out = {data_in[6:0], (op_sel == 3'h3) ? data_in[7] : flags_in[`FLAG_C]};
        flags_out[`FLAG_C] = data_in[7];
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
      end
      default:
        data_out = data_in;
    endcase
  end
endmodule
`default_nettype wire

// ==== bench/exec_ops_chk.sv ====
// Checker for exec_ops: pulses, stack steps and enable flops.
// Assumes it is bound to exec_ops and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module exec_ops_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched signals
  input wire logic interrupt_enable_op,
  input wire logic mem_wr_reg,
  input wire logic busy_reg,
  input wire logic done_reg,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic active_int_enable_ff,
  input wire logic saved_int_enable_ff,
  input wire logic interrupt_return_op_seen_reg
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  done_pulse_a: assert property (done_reg |=> !done_reg)
    else $error("done held too long");
  done_ends_busy_a: assert property (done_reg |-> $past(busy_reg))
    else $error("done without busy");
  op_length_a: assert property ($rose(busy_reg) |-> ##[4:23] done_reg)
    else $error("operation too long");
  sp_step_a: assert property ($changed(stack_pointer_reg) |->
    stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002) else $error("stack step wrong");
  write_in_op_a: assert property (mem_wr_reg |-> busy_reg)
    else $error("write outside operation");
  enable_set_a: assert property (interrupt_enable_op |=> active_int_enable_ff && saved_int_enable_ff)
    else $error("enable not set");
  enable_copy_a: assert property ($changed(active_int_enable_ff) && !$past(interrupt_enable_op) |->
    active_int_enable_ff == saved_int_enable_ff) else $error("active enable not copied");
  interrupt_return_op_pulse_a: assert property (interrupt_return_op_seen_reg |=> !interrupt_return_op_seen_reg)
    else $error("return marker too long");
  interrupt_return_op_done_a: assert property (interrupt_return_op_seen_reg |-> ##[0:14] done_reg)
    else $error("return marker not followed by done");
  cover property (interrupt_return_op_seen_reg);
  cover property (mem_wr_reg);
  cover property ($changed(stack_pointer_reg));
endmodule
bind exec_ops exec_ops_chk i_exec_ops_chk (.sys_clk, .rst_n, .interrupt_enable_op, .mem_wr_reg, .busy_reg,
  .done_reg, .stack_pointer_reg, .active_int_enable_ff, .saved_int_enable_ff, .interrupt_return_op_seen_reg);
`default_nettype wire

// ==== bench/stack_mem_model.sv ====
// Program and stack memory on the far side of exec_ops.
// Assumes reads answer the cycle after the strobe, writes land at once.
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model (
  // Clock
  input wire logic sys_clk,
  // Bus from the execution unit
  input wire logic [15:0] mem_addr_reg,
  input wire logic [7:0] mem_wdata_reg,
  input wire logic mem_rd_reg,
  input wire logic mem_wr_reg,
  // Read data
  output var logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial
  begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
  end
  always @(posedge sys_clk)
  begin
    if (mem_wr_reg)
      mem[mem_addr_reg] <= mem_wdata_reg;
    // Churn outside reads so stale bytes never pass for answers
    mem_rdata <= mem_rd_reg ? mem[mem_addr_reg] : ~mem_rdata;
  end
endmodule
`default_nettype wire

// ==== bench/bit_reset_return_rotate_left_ops_tb_top.sv ====
// Random and corner tests of exec_ops against the memory model.
// Assumes exec_ops, its checker and stack_mem_model are compiled.
`timescale 1ns/1ps
`default_nettype none
module bit_reset_return_rotate_left_ops_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, interrupt_enable_op = 1'b0;
  logic [7:0] instr_prefix = 8'h00, instr_opcode = 8'h00, instr_offset = 8'h00;
  logic [15:0] next_pc = 16'h0000, first_index_register = 16'h0000, second_index_register = 16'h0000;
  logic [7:0] mem_rdata, mem_wdata_reg, acc_reg, flags_reg, wr_d, fl, o;
  logic [15:0] mem_addr_reg, pc_reg, stack_pointer_reg, wr_a, sp_x;
  logic [47:0] gpr_reg;
  logic mem_rd_reg, mem_wr_reg, busy_reg, done_reg, active_int_enable_ff, saved_int_enable_ff;
  logic interrupt_return_op_seen_reg, saw_interrupt_return_op, ie_x;
  logic [7:0] gr [0:7];
  logic [31:0] lfsr_q = 32'hCFFC, v;
  int failures = 0, compares = 0;
  exec_ops i_exec_ops (.sys_clk, .rst_n, .instr_valid, .instr_prefix, .instr_opcode, .instr_offset, .next_pc,
    .first_index_register, .second_index_register, .interrupt_enable_op, .mem_rdata, .mem_addr_reg,
    .mem_wdata_reg, .mem_rd_reg, .mem_wr_reg, .busy_reg, .done_reg, .pc_reg, .stack_pointer_reg, .acc_reg,
    .flags_reg, .gpr_reg, .active_int_enable_ff, .saved_int_enable_ff, .interrupt_return_op_seen_reg);
  stack_mem_model i_stack_mem_model (.sys_clk, .mem_addr_reg, .mem_wdata_reg, .mem_rd_reg, .mem_wr_reg,
    .mem_rdata);
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  // Gives {flags, data}; flag bits 5 and 3 are left unmodelled
  function automatic logic [15:0] alu(input logic [7:0] op, d, f, input logic acc);
    logic [7:0] r;
    r = {d[6:0], op[4] ? f[0] : d[7]};
    if (op[7])
      return {f, d & ~(8'h01 << op[5:3])};
    if (acc)
      return {f[7:6], 3'b000, f[2], 1'b0, d[7], r};
    return {r[7], r == 8'h00, 3'b000, ~^r, 1'b0, d[7], r};
  endfunction
  task automatic check(input string what, input logic [47:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic issue(input logic [7:0] p, op, f, input int t);
    int n;
    n = 0;
    saw_interrupt_return_op = 1'b0;
    wr_d = 8'hxx;
    {instr_prefix, instr_opcode, instr_offset} = {p, op, f};
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    while (done_reg !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
      saw_interrupt_return_op = saw_interrupt_return_op | interrupt_return_op_seen_reg;
      if (mem_wr_reg === 1'b1)
        {wr_a, wr_d} = {mem_addr_reg, mem_wdata_reg};
    end
    if (n == 40)
    begin
      failures++;
      tally_and_finish();
    end
    check("cycles", t, n);
  endtask
  task automatic do_op(input logic [7:0] p, op, f);
    logic [15:0] a, r;
    int k;
    k = op[2:0];
    a = p == 8'hCB ? {gr[4], gr[5]} : (p == 8'hDD ? first_index_register : second_index_register) + {{8{f[7]}}, f};
    r = alu(op, k == 6 ? i_stack_mem_model.mem[a] : gr[k], fl, p == 8'h00);
    issue(p, op, f, p == 8'h00 ? 4 : k != 6 ? 8 : p == 8'hCB ? 15 : 23);
    if (k == 6)
      check("mem write", {a, r[7:0]}, {wr_a, wr_d});
    else
      gr[k] = r[7:0];
    fl = r[15:8];
    check("gpr", {gr[0], gr[1], gr[2], gr[3], gr[4], gr[5]}, gpr_reg);
    check("acc", gr[7], acc_reg);
    check("flags", fl & 8'hD7, flags_reg & 8'hD7);
  endtask
  task automatic do_ret(input logic [7:0] p, op);
    logic [15:0] tgt;
    logic [3:0] cf;
    logic tk;
    logic [31:0] w;
    tgt = {i_stack_mem_model.mem[sp_x + 16'h0001], i_stack_mem_model.mem[sp_x]};
    cf = {fl[7], fl[2], fl[0], fl[6]};
    tk = op[0] || cf[op[5:4]] == op[3];
    w = rnd();
    next_pc = w[15:0];
    issue(p, op, 8'h00, p == 8'hED ? 14 : op[0] ? 10 : tk ? 11 : 5);
    sp_x = tk ? sp_x + 16'h0002 : sp_x;
    check("pc", tk ? tgt : next_pc, pc_reg);
    check("sp", sp_x, stack_pointer_reg);
    check("interrupt_return_op marker", p == 8'hED && op == 8'h4D, saw_interrupt_return_op);
    check("enables", {ie_x, ie_x}, {active_int_enable_ff, saved_int_enable_ff});
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
      gr[i] = 8'h00;
    {fl, sp_x, ie_x} = {8'h00, 16'hFFFF, 1'b0};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    check("sp reset", 16'hFFFF, stack_pointer_reg);
    for (int c = 0; c < 8; c++)
      do_ret(8'h00, {2'b11, c[2:0], 3'b000});
    do_ret(8'h00, 8'hC9);
    interrupt_enable_op = 1'b1;
    @(negedge sys_clk);
    interrupt_enable_op = 1'b0;
    ie_x = 1'b1;
    do_ret(8'hED, 8'h4D);
    do_ret(8'hED, 8'h45);
    do_op(8'hCB, 8'h06, 8'h00);
    do_op(8'h00, 8'h17, 8'h00);
    do_op(8'h00, 8'h07, 8'h00);
    $display("corner tests done");
    repeat (80)
    begin
      v = rnd();
      {first_index_register, second_index_register} = {v[31:16], v[15:0] ^ 16'h5A5A};
      o = v[3] ? {2'b10, v[6:4], v[9:7]} : {3'b000, v[4], 1'b0, v[9:7]};
      case (v[1:0])
        2'd0: do_op(8'hCB, o, 8'h00);
        2'd1: do_op(v[12] ? 8'hDD : 8'hFD, {o[7:3], 3'b110}, v[23:16]);
        2'd2: do_op(8'h00, v[4] ? 8'h17 : 8'h07, 8'h00);
        default: do_ret(8'h00, v[8] ? 8'hC9 : {2'b11, v[6:4], 3'b000});
      endcase
    end
    $display("random tests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
